// >>> common/cpld_io_pkg.sv
// Constants, field layouts and config types for the I/O control fabric.
// Assumes one logic group of sixteen macrocells and eight user I/O pins.
`default_nettype none
package cpld_io_pkg;
  localparam int NPIN      = 8;
  localparam int NMC       = 16;
  localparam int NGI       = 8;
  localparam int NGOE      = 6;
  localparam int NBASICOE  = 2;
  localparam int PT_PER_MC = 5;
  localparam int MAX_BORROW = 3;
  localparam int NPT       = NMC * PT_PER_MC;
  localparam int NTERM     = NMC + NPT;
  localparam int NSRC      = 32;
  localparam int TEST_PIN0 = 4;
  localparam int TCK_PIN   = 4;
  localparam int TMS_PIN   = 5;
  localparam int TDI_PIN   = 6;
  localparam int TDO_PIN   = 7;
  localparam int OESEL_LINE0 = 2;

  // Synchroniser vector layout
  localparam int S_ENA  = NPIN;
  localparam int S_ENB  = NPIN + 1;
  localparam int S_DED  = NPIN + 2;
  localparam int S_GCLR = NPIN + 4;
  localparam int S_ISP  = NPIN + 5;
  localparam int S_SCAN = NPIN + 6;
  localparam int SYNC_W = NPIN + 7;

  localparam int AW = 12;
  localparam logic [AW-1:0] OFS_CTRL   = 12'h000;
  localparam logic [AW-1:0] OFS_STATUS = 12'h004;
  localparam logic [AW-1:0] OFS_TIDX   = 12'h008;
  localparam logic [AW-1:0] OFS_TDATA  = 12'h00c;
  localparam logic [AW-1:0] OFS_PIN    = 12'h040;
  localparam logic [AW-1:0] OFS_GOE    = 12'h080;
  localparam logic [AW-1:0] OFS_MC     = 12'h0c0;
  localparam logic [AW-1:0] OFS_ROUTE  = 12'h100;

  localparam int CTRL_ENH   = 0;
  localparam int ST_ISP     = 0;
  localparam int ST_TEST    = 1;
  localparam int ST_PIN_LSB = 8;
  localparam int ST_MC_LSB  = 16;

  typedef enum logic [1:0] {
    DIR_IN    = 2'h0,
    DIR_OUT   = 2'h1,
    DIR_BIDIR = 2'h2,
    DIR_ALT   = 2'h3
  } pin_dir_t;

  typedef enum logic [1:0] {
    SRC_ENPIN = 2'h0,
    SRC_PIN   = 2'h1,
    SRC_MC    = 2'h2,
    SRC_NONE  = 2'h3
  } oe_kind_t;

  typedef struct packed {
    logic [2:0] oeSel;
    pin_dir_t   dir;
  } pin_cfg_t;

  typedef struct packed {
    logic       inv;
    logic [3:0] idx;
    oe_kind_t   kind;
  } oe_src_t;

  typedef struct packed {
    logic [1:0] borrow;
    logic       inv;
    logic       registered;
  } mc_cfg_t;

  typedef struct packed {
    logic [NMC-1:0] shared;
    logic [NGI-1:0] neg;
    logic [NGI-1:0] pos;
  } term_t;

  localparam pin_cfg_t PIN_CFG_RST = '0;
  localparam oe_src_t  OE_SRC_RST  = '0;
  localparam mc_cfg_t  MC_CFG_RST  = '0;
  localparam term_t    TERM_RST    = '0;

  // Programmer-side time budget, smallest device
  localparam real PROG_PULSE_S    = 4.02;
  localparam int  PROG_TCK_CYCLES = 342000;
  localparam real VER_PULSE_S     = 0.03;
  localparam int  VER_TCK_CYCLES  = 200000;

  function automatic real prog_time_s(input real ftckHz);
    return PROG_PULSE_S + PROG_TCK_CYCLES / ftckHz;
  endfunction

  function automatic real verify_time_s(input real ftckHz);
    return VER_PULSE_S + VER_TCK_CYCLES / ftckHz;
  endfunction
endpackage
`default_nettype wire

// >>> hw/cpld_io_fabric.sv
// I/O control, routing array, expanders and macrocells of one logic group,
// configured over APB. Assumes an external TAP drives the mode inputs.
//
// Contract
// - Each pin separately set as input, output or bidirectional.
// - Pin driver enable picks a global enable line, constant low or high.
// - Basic variant: two global enables from active-low dedicated pins.
// - Enhanced variant: six enables from enable pins, pins or macrocells.
// - Constant-low selection keeps the driver off; pin is pure input.
// - Constant-high selection drives the macrocell output onto any pin not set as input.
// - Pin feedback and macrocell feedback are separate paths.
// - During programming all user pins outside the test port float with weak pull-up.
// - Each macrocell is registered or combinational.
// - Routing array gates each source into group inputs by AND cells.
// - Logic group gets routed inputs plus global register controls.
// - Sixteen shared single terms, inverted, fed back, usable by all.
// - Macrocell OR takes five own terms plus up to fifteen borrowed.
// - While scan or programming runs, four pins act as test port.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module cpld_io_fabric (
  input  wire logic                         mclk,
  input  wire logic                         nrst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [cpld_io_pkg::AW-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [cpld_io_pkg::NPIN-1:0] pinIn,
  output logic      [cpld_io_pkg::NPIN-1:0] pinOut,
  output logic      [cpld_io_pkg::NPIN-1:0] pinOe,
  output logic      [cpld_io_pkg::NPIN-1:0] pinPullup,
  input  wire logic                         globalEnablePinAN,
  input  wire logic                         globalEnablePinBN,
  input  wire logic [1:0]                   dedIn,
  input  wire logic                         globalClearN,
  input  wire logic                         programActive,
  input  wire logic                         scanActive,
  input  wire logic                         testTdo,
  input  wire logic                         testTdoEn,
  output logic                              testTck,
  output logic                              testTms,
  output logic                              testTdi
);
  import cpld_io_pkg::*;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              enhanced_q;
  pin_cfg_t          pinCfg_q [NPIN];
  oe_src_t           goeCfg_q [NGOE];
  mc_cfg_t           mcCfg_q  [NMC];
  logic [NSRC-1:0]   route_q  [NGI];
  term_t             termMem_q [NTERM];
  logic [6:0]        tidx_q;
  logic [31:0]       prdata_q;
  logic [NMC-1:0]    mcReg_q;
  logic [NMC-1:0]    mcFb_q;

  logic [NPIN-1:0]   pinSync;
  logic [NPIN-1:0]   pinFb;
  logic              enAN;
  logic              enBN;
  logic              gClear;
  logic              inProgram;
  logic              testPort;
  logic [NGOE-1:0]   gOe;
  logic [NSRC-1:0]   sources;
  logic [NGI-1:0]    groupIn;
  logic [NMC-1:0]    shared;
  logic [NPT-1:0]    ptHit;
  logic [NMC-1:0]    pt5;
  logic [NMC-1:0]    lent;
  logic [NMC-1:0]    orVal;
  logic [NMC-1:0]    mcComb;
  logic [NMC-1:0]    mcOut;

  // Pins and mode strobes come from outside mclk
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {scanActive, programActive, globalClearN, dedIn,
                  globalEnablePinBN, globalEnablePinAN, pinIn};
      sync2_q <= sync1_q;
    end
  end

  assign pinSync   = sync2_q[NPIN-1:0];
  assign enAN      = sync2_q[S_ENA];
  assign enBN      = sync2_q[S_ENB];
  assign gClear    = ~sync2_q[S_GCLR];
  assign inProgram = sync2_q[S_ISP];
  assign testPort  = sync2_q[S_ISP] | sync2_q[S_SCAN];
  // TCK is oversampled, so it must stay well below mclk/4
  assign testTck   = pinSync[TCK_PIN];
  assign testTms   = pinSync[TMS_PIN];
  assign testTdi   = pinSync[TDI_PIN];

  // APB decode
  logic [3:0] wIdx;
  logic       aligned;
  logic       hitCtrl;
  logic       hitStat;
  logic       hitTidx;
  logic       hitTdata;
  logic       hitPin;
  logic       hitGoe;
  logic       hitMc;
  logic       hitRoute;
  logic       mapped;
  logic       wrEn;
  logic       dataAcc;
  logic       tidxOk;

  assign wIdx     = paddr[5:2];
  assign aligned  = paddr[1:0] == 2'h0;
  assign hitCtrl  = aligned && paddr[AW-1:2] == OFS_CTRL[AW-1:2];
  assign hitStat  = aligned && paddr[AW-1:2] == OFS_STATUS[AW-1:2];
  assign hitTidx  = aligned && paddr[AW-1:2] == OFS_TIDX[AW-1:2];
  assign hitTdata = aligned && paddr[AW-1:2] == OFS_TDATA[AW-1:2];
  assign hitPin   = aligned && paddr[AW-1:6] == OFS_PIN[AW-1:6]
                    && 32'(wIdx) < NPIN;
  assign hitGoe   = aligned && paddr[AW-1:6] == OFS_GOE[AW-1:6]
                    && 32'(wIdx) < NGOE;
  assign hitMc    = aligned && paddr[AW-1:6] == OFS_MC[AW-1:6];
  assign hitRoute = aligned && paddr[AW-1:6] == OFS_ROUTE[AW-1:6]
                    && 32'(wIdx) < NGI;
  assign mapped   = hitCtrl | hitStat | hitTidx | hitTdata | hitPin
                    | hitGoe | hitMc | hitRoute;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;
  assign wrEn     = psel & penable & pwrite & mapped;
  assign dataAcc  = psel & penable & hitTdata;
  assign tidxOk   = 32'(tidx_q) < NTERM;
  assign prdata   = prdata_q;

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    if (hitCtrl) begin
      rdMux[CTRL_ENH] = enhanced_q;
    end else if (hitStat) begin
      rdMux[ST_ISP]  = inProgram;
      rdMux[ST_TEST] = testPort;
      rdMux[ST_PIN_LSB +: NPIN] = pinSync;
      rdMux[ST_MC_LSB +: NMC]   = mcFb_q;
    end else if (hitTidx) begin
      rdMux[6:0] = tidx_q;
    end else if (hitTdata && tidxOk) begin
      rdMux = termMem_q[tidx_q];
    end else if (hitPin) begin
      rdMux[$bits(pin_cfg_t)-1:0] = pinCfg_q[wIdx[2:0]];
    end else if (hitGoe) begin
      rdMux[$bits(oe_src_t)-1:0] = goeCfg_q[wIdx[2:0]];
    end else if (hitMc) begin
      rdMux[$bits(mc_cfg_t)-1:0] = mcCfg_q[wIdx];
    end else if (hitRoute) begin
      rdMux = route_q[wIdx[2:0]];
    end
  end

  // Read data is captured in the setup cycle, so no wait states are needed
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      enhanced_q <= 1'b0;
      tidx_q     <= 7'h0;
    end else begin
      if (wrEn && hitCtrl) begin
        enhanced_q <= pwdata[CTRL_ENH];
      end
      // Index steps on every data access to allow burst loading
      if (wrEn && hitTidx) begin
        tidx_q <= pwdata[6:0];
      end else if (dataAcc) begin
        tidx_q <= tidx_q + 7'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NPIN; i++) pinCfg_q[i] <= PIN_CFG_RST;
      for (int i = 0; i < NGOE; i++) goeCfg_q[i] <= OE_SRC_RST;
      for (int i = 0; i < NMC; i++) mcCfg_q[i] <= MC_CFG_RST;
      for (int i = 0; i < NGI; i++) route_q[i] <= '0;
    end else if (wrEn) begin
      if (hitPin) begin
        pinCfg_q[wIdx[2:0]] <= pin_cfg_t'(pwdata[$bits(pin_cfg_t)-1:0]);
      end
      if (hitGoe) begin
        goeCfg_q[wIdx[2:0]] <= oe_src_t'(pwdata[$bits(oe_src_t)-1:0]);
      end
      if (hitMc) begin
        mcCfg_q[wIdx] <= mc_cfg_t'(pwdata[$bits(mc_cfg_t)-1:0]);
      end
      if (hitRoute) begin
        route_q[wIdx[2:0]] <= pwdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      for (int i = 0; i < NTERM; i++) termMem_q[i] <= TERM_RST;
    end else if (wrEn && hitTdata && tidxOk) begin
      termMem_q[tidx_q] <= term_t'(pwdata);
    end
  end

  genvar l;
  generate
    for (l = 0; l < NGOE; l++) begin : g_goe
      logic srcBit;
      logic lineEnh;
      assign srcBit = goeCfg_q[l].kind == SRC_ENPIN
                        ? (goeCfg_q[l].idx[0] ? enBN : enAN)
                    : goeCfg_q[l].kind == SRC_PIN
                        ? pinSync[goeCfg_q[l].idx[2:0]]
                    : goeCfg_q[l].kind == SRC_MC
                        ? mcFb_q[goeCfg_q[l].idx] : 1'b0;
      assign lineEnh = srcBit ^ goeCfg_q[l].inv;
      if (l < NBASICOE) begin : g_basic
        assign gOe[l] = enhanced_q ? lineEnh
                                   : ~(l == 0 ? enAN : enBN);
      end else begin : g_ext
        assign gOe[l] = enhanced_q & lineEnh;
      end
    end
  endgenerate

  assign sources = {4'h0, mcFb_q, pinFb, sync2_q[S_DED +: 2], enBN, enAN};

  genvar g;
  generate
    for (g = 0; g < NGI; g++) begin : g_route
      assign groupIn[g] = |(route_q[g] & sources);
    end
  endgenerate

  function automatic logic term_hit(input term_t t, input logic [31:0] lit);
    return (|t) & (&(~t | lit));
  endfunction

  // Shared terms see only group inputs, so no loop through themselves
  // inverted shared expanders
  genvar k;
  generate
    for (k = 0; k < NMC; k++) begin : g_shared
      term_t st;
      assign st = '{shared: '0, neg: termMem_q[k].neg,
                    pos: termMem_q[k].pos};
      assign shared[k] = ~term_hit(st, {16'h0, ~groupIn, groupIn});
    end
    for (k = 0; k < NPT; k++) begin : g_pt
      assign ptHit[k] = term_hit(termMem_q[NMC + k],
                                 {shared, ~groupIn, groupIn});
    end
    for (k = 0; k < NMC; k++) begin : g_pt5
      assign pt5[k] = |ptHit[k*PT_PER_MC +: PT_PER_MC];
    end
  endgenerate

  always_comb begin
    lent  = '0;
    orVal = '0;
    for (int m = 0; m < NMC; m++) begin
      for (int d = 1; d <= MAX_BORROW; d++) begin
        if (m - d >= 0 && 32'(mcCfg_q[m - d].borrow) >= d) begin
          lent[m] = 1'b1;
        end
      end
    end
    for (int m = 0; m < NMC; m++) begin
      orVal[m] = pt5[m] & ~lent[m];
      for (int d = 1; d <= MAX_BORROW; d++) begin
        if (m + d < NMC && 32'(mcCfg_q[m].borrow) >= d) begin
          orVal[m] = orVal[m] | pt5[m + d];
        end
      end
    end
  end

  genvar m;
  generate
    for (m = 0; m < NMC; m++) begin : g_mc
      assign mcComb[m] = orVal[m] ^ mcCfg_q[m].inv;
      assign mcOut[m]  = mcCfg_q[m].registered ? mcReg_q[m] : mcComb[m];
    end
  endgenerate

  // Feedback goes through a flop: breaks array loops, costs one cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mcReg_q <= '0;
      mcFb_q  <= '0;
    end else begin
      mcReg_q <= gClear ? '0 : mcComb;
      mcFb_q  <= mcOut;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPIN; p++) begin : g_pin
      logic testPin;
      logic selOe;
      logic dirIn;
      logic dirOut;
      assign testPin = testPort && p >= TEST_PIN0;
      assign dirIn   = pinCfg_q[p].dir == DIR_IN;
      assign dirOut  = pinCfg_q[p].dir == DIR_OUT;
      assign selOe = pinCfg_q[p].oeSel == 3'h0 ? 1'b0
                   : pinCfg_q[p].oeSel == 3'h1 ? 1'b1
                   : gOe[32'(pinCfg_q[p].oeSel) - OESEL_LINE0];
      assign pinOe[p] = testPin ? (p == TDO_PIN && testTdoEn)
                      : inProgram ? 1'b0
                      : dirIn ? 1'b0 : selOe;
      assign pinOut[p]    = testPin && p == TDO_PIN ? testTdo : mcOut[p];
      assign pinPullup[p] = inProgram & ~testPin;
      assign pinFb[p] = pinSync[p] & ~dirOut & ~testPin;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> testbench/cpld_io_monitor.sv
// Checker of pin enable, pull-up and test-port relations of the fabric.
// Assumes a bind to cpld_io_fabric; it watches that module's ports only.
`timescale 1ns/1ns
`default_nettype none
module cpld_io_monitor (
  input wire logic                         mclk,
  input wire logic                         nrst,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [cpld_io_pkg::AW-1:0]   paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [cpld_io_pkg::NPIN-1:0] pinIn,
  input wire logic [cpld_io_pkg::NPIN-1:0] pinOut,
  input wire logic [cpld_io_pkg::NPIN-1:0] pinOe,
  input wire logic [cpld_io_pkg::NPIN-1:0] pinPullup,
  input wire logic                         programActive,
  input wire logic                         scanActive,
  input wire logic                         testTdo,
  input wire logic                         testTdoEn,
  input wire logic                         testTck,
  input wire logic                         testTms,
  input wire logic                         testTdi
);
  import cpld_io_pkg::*;
  pin_cfg_t        cfgQ [NPIN];
  logic [NPIN-1:0] inV, offV, onV;
  logic            cfgWr;
  // Shadow of pin config, written on the same APB edge as the fabric
  assign cfgWr = psel && penable && pwrite && paddr[1:0] == 2'h0
               && paddr[11:5] == 7'h02;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cfgQ <= '{default: PIN_CFG_RST};
    end else if (cfgWr) begin
      cfgQ[paddr[4:2]] <= pin_cfg_t'(pwdata[4:0]);
    end
  end
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      inV[p]  = cfgQ[p].dir == DIR_IN;
      offV[p] = cfgQ[p].oeSel == 3'h0;
      onV[p]  = cfgQ[p].oeSel == 3'h1 && !inV[p];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Three samples, so the two-flop mode synchronisers have settled
  sequence s_normal;
    (!programActive && !scanActive)[*3];
  endsequence
  property p_in_only;
    s_normal |-> (pinOe & inV) == '0;
  endproperty
  a_in_only: assert property (p_in_only)
    else $error("input-only pin driven");
  property p_const_low;
    s_normal |-> (pinOe & offV) == '0;
  endproperty
  a_const_low: assert property (p_const_low)
    else $error("constant-low pin driven");
  property p_const_high;
    s_normal |-> (pinOe & onV) == onV;
  endproperty
  a_const_high: assert property (p_const_high)
    else $error("constant-high pin not driven");
  property p_prog_float;
    programActive[*3] |-> pinOe[6:0] == 7'h00 && pinPullup[3:0] == 4'hf;
  endproperty
  a_prog_float: assert property (p_prog_float)
    else $error("user pin not floating during programming");
  property p_resume;
    s_normal |-> pinPullup == 8'h00;
  endproperty
  a_resume: assert property (p_resume)
    else $error("pull-up left on after programming");
  property p_test_pullup;
    pinPullup[7:4] == 4'h0;
  endproperty
  a_test_pullup: assert property (p_test_pullup)
    else $error("pull-up on a test-port pin");
  property p_tdo;
    (programActive || scanActive)[*3] |-> pinOe[7] == testTdoEn
      && pinOut[7] == testTdo && pinOe[6:4] == 3'h0;
  endproperty
  a_tdo: assert property (p_tdo)
    else $error("test-port pins not routed");
  property p_tck;
    $past(nrst) && $past(nrst, 2) |-> testTck == $past(pinIn[4], 2)
      && testTms == $past(pinIn[5], 2) && testTdi == $past(pinIn[6], 2);
  endproperty
  a_tck: assert property (p_tck)
    else $error("test clock does not follow its pin");
endmodule
`default_nettype wire

// >>> testbench/isp_programmer_model.sv
// Behavioural in-circuit programmer driving the test-clock, mode and data
// pins. Assumes the bench pulses startReq for one clock while it is idle.
`timescale 1ns/1ns
`default_nettype none
module isp_programmer_model (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic startReq,
  input  wire logic verifyOnly,
  output logic      programActive,
  output logic      tckPin,
  output logic      tmsPin,
  output logic      tdiPin
);
  // Scaled: one clock per ms of pulse and per thousand shift cycles
  // program budget
  localparam int PROG_BUDGET = int'(cpld_io_pkg::PROG_PULSE_S * 1000.0)
                               + cpld_io_pkg::PROG_TCK_CYCLES / 1000;
  localparam int VER_BUDGET  = int'(cpld_io_pkg::VER_PULSE_S * 1000.0)
                               + cpld_io_pkg::VER_TCK_CYCLES / 1000;
  logic [15:0] leftQ;
  assign programActive = leftQ != 16'h0;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      leftQ  <= 16'h0;
      tckPin <= 1'b0;
      tmsPin <= 1'b0;
      tdiPin <= 1'b0;
    end else if (!programActive) begin
      // Clock still between frames; released lines never hold a value
      tckPin <= 1'b0;
      tmsPin <= ~tmsPin;
      tdiPin <= ~tdiPin;
      if (startReq) begin
        leftQ <= verifyOnly ? 16'(VER_BUDGET) : 16'(PROG_BUDGET);
      end
    end else begin
      leftQ  <= leftQ - 16'h1;
      // TCK at mclk/8, inside the fabric's oversampling limit
      tckPin <= leftQ[2];
      tmsPin <= leftQ[4];
      tdiPin <= leftQ[0];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Bench for the I/O fabric: pin-enable table, macrocell, programming, scan.
// Assumes the package, fabric, checker and programmer model compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cpld_io_pkg::*;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [2:0]  inp;
    int          pin;
    logic        oe;
  } row_t;
  // inp is {enable pin A, enable pin B, pin 3 level}
  row_t rows [14] = '{
    '{12'h040, 32'h05, 3'h6, 0, 1'b1}, '{12'h044, 32'h01, 3'h6, 1, 1'b0},
    '{12'h048, 32'h04, 3'h6, 2, 1'b0}, '{12'h04c, 32'h06, 3'h6, 3, 1'b1},
    '{12'h040, 32'h09, 3'h2, 0, 1'b1}, '{12'h040, 32'h09, 3'h6, 0, 1'b0},
    '{12'h044, 32'h0d, 3'h4, 1, 1'b1}, '{12'h044, 32'h11, 3'h4, 1, 1'b0},
    '{12'h000, 32'h01, 3'h6, 1, 1'b1}, '{12'h088, 32'h43, 3'h2, 1, 1'b1},
    '{12'h04c, 32'h00, 3'h6, 3, 1'b0}, '{12'h08c, 32'h0d, 3'h7, 2, 1'b0},
    '{12'h048, 32'h15, 3'h7, 2, 1'b1}, '{12'h048, 32'h15, 3'h6, 2, 1'b0}
  };
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
  logic        enAN, enBN, programActive, scanActive, testTdo, testTdoEn;
  logic        testTck, testTms, testTdi, startReq, verifyOnly;
  logic        clrN;
  logic [1:0]  ded;
  logic        tck, tms, tdi;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [7:0]  pinIn, pinOut, pinOe, pinPullup;
  logic [3:0]  userIn;
  int          errTotal, comparisons;
  // Wire level: the fabric where it drives, else the outside party
  assign pinIn = (pinOe & pinOut) | (~pinOe & {1'b1, tdi, tms, tck, userIn});
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  cpld_io_fabric u_cpld_io_fabric (
    .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pinIn, .pinOut, .pinOe, .pinPullup,
    .globalEnablePinAN(enAN), .globalEnablePinBN(enBN), .dedIn(ded),
    .globalClearN(clrN), .programActive, .scanActive, .testTdo,
    .testTdoEn, .testTck, .testTms, .testTdi
  );
  isp_programmer_model u_isp_programmer_model (
    .mclk, .nrst, .startReq, .verifyOnly, .programActive,
    .tckPin(tck), .tmsPin(tms), .tdiPin(tdi)
  );
  task automatic chk1(input logic g, input logic x);
    comparisons++;
    if (g !== x) begin
      errTotal++;
      $display("[ERR] %0t bit %b, expected %b", $time, g, x);
    end
  endtask
  task automatic chkw(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      errTotal++;
      $display("[ERR] %0t word %h, expected %h", $time, g, x);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // No fixed wait count; only the watchdog ends a stalled transfer
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", errTotal, comparisons);
    if (errTotal == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    give_verdict();
  end
  initial begin
    {nrst, psel, penable, pwrite, scanActive} = 5'h0;
    {testTdo, testTdoEn, startReq, verifyOnly} = 4'h0;
    {clrN, ded} = 3'h4;
    {enAN, enBN, paddr, pwdata, userIn} = {2'h3, 12'h0, 32'h0, 4'h0};
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    chkw({prdata[15:0], pinOe, pinPullup}, 32'h0);
    @(posedge mclk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, rdata, rerr);
      {enAN, enBN, userIn[3]} <= rows[i].inp;
      settle(3);
      chk1(pinOe[rows[i].pin], rows[i].oe);
    end
    apb(1'b1, OFS_PIN, 32'h5, rdata, rerr);
    apb(1'b1, OFS_MC, 32'h2, rdata, rerr);
    settle(1);
    chk1(pinOut[0], 1'b1);
    apb(1'b1, OFS_PIN, 32'h4, rdata, rerr);
    settle(3);
    apb(1'b0, OFS_STATUS, 32'h0, rdata, rerr);
    chkw(rdata & 32'h0001_0100, 32'h0001_0000);
    apb(1'b1, OFS_PIN, 32'h5, rdata, rerr);
    for (int m = 0; m < 2; m++) begin
      @(posedge mclk);
      startReq <= 1'b1;
      verifyOnly <= (m == 0);
      @(posedge mclk);
      startReq <= 1'b0;
      settle(3);
      chk1(|pinOe[6:0], 1'b0);
      chk1(&pinPullup[3:0], 1'b1);
      while (programActive === 1'b1) @(posedge mclk);
      settle(3);
      chkw({23'h0, pinOe[0], pinPullup}, 32'h100);
    end
    @(posedge mclk);
    {scanActive, testTdoEn, testTdo} <= 3'h7;
    settle(3);
    chkw({29'h0, pinOe[7], pinOut[7], |pinOe[6:4]}, 32'h6);
    @(posedge mclk);
    scanActive <= 1'b0;
    apb(1'b0, 12'h200, 32'h0, rdata, rerr);
    chk1(rerr, 1'b1);
    chkw(rdata, 32'h0);
    // Macrocell 0 on pin 0: group input 0 = pin 3 or dedicated input 0
    apb(1'b1, OFS_ROUTE, 32'h84, rdata, rerr);
    apb(1'b1, OFS_TIDX, 32'h0, rdata, rerr);
    apb(1'b1, OFS_TDATA, 32'h1, rdata, rerr);
    apb(1'b1, OFS_TIDX, 32'h10, rdata, rerr);
    apb(1'b1, OFS_TDATA, 32'h1_0000, rdata, rerr);
    apb(1'b1, OFS_MC, 32'h0, rdata, rerr);
    userIn[3] <= 1'b1;
    settle(3);
    chk1(pinOut[0], 1'b0);
    apb(1'b1, OFS_TIDX, 32'h15, rdata, rerr);
    apb(1'b1, OFS_TDATA, 32'h1, rdata, rerr);
    apb(1'b1, OFS_MC, 32'h4, rdata, rerr);
    settle(1);
    chk1(pinOut[0], 1'b1);
    apb(1'b0, OFS_STATUS, 32'h0, rdata, rerr);
    chkw(rdata & 32'h3_0000, 32'h1_0000);
    apb(1'b1, OFS_MC, 32'h1, rdata, rerr);
    userIn[3] <= 1'b0;
    settle(2);
    chk1(pinOut[0], 1'b0);
    settle(1);
    chk1(pinOut[0], 1'b1);
    @(posedge mclk);
    ded <= 2'h1;
    settle(3);
    chk1(pinOut[0], 1'b0);
    @(posedge mclk);
    {ded, clrN} <= 3'h0;
    settle(3);
    chk1(pinOut[0], 1'b0);
    give_verdict();
  end
endmodule
bind cpld_io_fabric cpld_io_monitor u_cpld_io_monitor (
  .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pinIn,
  .pinOut, .pinOe, .pinPullup, .programActive, .scanActive, .testTdo,
  .testTdoEn, .testTck, .testTms, .testTdi
);
`default_nettype wire
